// ===== rtl/mmno_core.sv
// Single-cycle move, multiply and negate execution unit with AXI4-Lite access
// Summary of operation
// RL1 - Literal load copies immediate into accumulator
// RL2 - Store writes accumulator to file, flags kept
// RL3 - File address comes from 8-bit field
// RL4 - Access bit picks access bank or bank
// RL5 - Extended set, low field uses indexed offset
// RL6 - Literal multiply gives 16-bit product pair
// RL7 - File multiply into product pair, sources kept
// RL8 - Multiplies never touch any status flag
// RL9 - Negate writes two's complement, updates flags
// RL10 - Bank load: decode, read, process, write
// RL11 - Bank select upper four bits forced zero
// RL12 - No-op changes nothing; four phases each
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module mmno_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [1:0] qph_q;
    logic pend_q, run_q, busy, ext_q, sw_wr;
    logic ph_decode, ph_read, ph_process, ph_write;
    logic [15:0] instr_q, prod_res_q;
    mmno_pkg::mmno_op_t op_q, op_d;
    logic [11:0] ea_q, ea_d, index_q, maddr_q;
    logic [7:0] opnd_q, neg_res_q, acc_q, awaddr_q;
    logic [7:0] product_low_byte_q, product_high_byte_q;
    logic [4:0] neg_flags_q, status_q;
    logic [3:0] bank_q, wstrb_q;
    logic [7:0] mem_q [mmno_pkg::MEM_DEPTH];
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q, wr_fire, wr_old_ok, rd_ok;
    logic [31:0] wdata_q, rdata_q, wr_old, wr_val, rd_val;
    logic [1:0] bresp_q, rresp_q;

    // Register read mux shared by reads and byte-lane merges
    function automatic logic [32:0] reg_read(input logic [7:0] addr);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (addr)
            mmno_pkg::OFS_CTRL: r[mmno_pkg::CTRL_EXT] = ext_q;
            mmno_pkg::OFS_INSTR: r[15:0] = instr_q;
            mmno_pkg::OFS_ACC: r[7:0] = acc_q;
            // Upper nibble of bank select always reads zero
            mmno_pkg::OFS_BANK: r[3:0] = bank_q;
            mmno_pkg::OFS_PRODUCT_LOW_BYTE: r[7:0] = product_low_byte_q;
            mmno_pkg::OFS_PRODUCT_HIGH_BYTE: r[7:0] = product_high_byte_q;
            mmno_pkg::OFS_STATUS:
            begin
                r[4:0] = status_q;
                r[mmno_pkg::ST_BUSY] = busy;
            end
            mmno_pkg::OFS_INDEX: r[11:0] = index_q;
            mmno_pkg::OFS_MADDR: r[11:0] = maddr_q;
            mmno_pkg::OFS_MDATA: r[7:0] = mem_q[maddr_q];
            default: r[32] = 1'b0;
        endcase
        return r;
    endfunction

    assign busy = pend_q | run_q;
    // RL12 - four quarter phases
    assign ph_decode = run_q && (qph_q == mmno_pkg::QP_DECODE);
    assign ph_read = run_q && (qph_q == mmno_pkg::QP_READ);
    assign ph_process = run_q && (qph_q == mmno_pkg::QP_PROCESS);
    assign ph_write = run_q && (qph_q == mmno_pkg::QP_WRITE);

    // Quarter-phase divider, free running
    always_ff @(posedge clk)
    begin
        if (rst)
            qph_q <= mmno_pkg::QP_DECODE;
        else
            qph_q <= qph_q + mmno_pkg::QP_STEP;
    end

    // AXI write channels accepted in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= mmno_pkg::RST_BYTE;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= mmno_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have_q)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_old_ok ? mmno_pkg::RESP_OKAY : mmno_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Byte-lane merge against current contents
    always_comb
    begin
        {wr_old_ok, wr_old} = reg_read(awaddr_q);
        for (int i = 0; i < 4; i++)
            wr_val[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : wr_old[i*8 +: 8];
    end

    // Core state is only written by software while idle
    assign sw_wr = wr_fire && wr_old_ok && !busy;

    // AXI read channel, one cycle answer
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    always_comb {rd_ok, rd_val} = reg_read(s_axi_araddr);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= mmno_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? mmno_pkg::RESP_OKAY : mmno_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Instruction issue; a cycle starts only on a phase boundary
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_q <= 1'b0;
            run_q <= 1'b0;
            instr_q <= mmno_pkg::RST_INSTR;
        end
        else
        begin
            if (qph_q == mmno_pkg::QP_WRITE)
            begin
                run_q <= pend_q;
                pend_q <= 1'b0;
            end
            if (sw_wr && awaddr_q == mmno_pkg::OFS_INSTR)
            begin
                pend_q <= 1'b1;
                instr_q <= wr_val[15:0];
            end
        end
    end

    // Opcode decode; unknown encodings run as no-op
    always_comb
    begin
        op_d = mmno_pkg::OP_NO_OP;
        if (instr_q[15:8] == mmno_pkg::OPC_LOAD_BANK)
            op_d = mmno_pkg::OP_LOAD_BANK_LITERAL;
        else if (instr_q[15:8] == mmno_pkg::OPC_LOAD_ACC)
            op_d = mmno_pkg::OP_LOAD_ACCUMULATOR_LITERAL;
        else if (instr_q[15:8] == mmno_pkg::OPC_MUL_LIT)
            op_d = mmno_pkg::OP_MULTIPLY_BY_LITERAL;
        else if (instr_q[15:9] == mmno_pkg::OPC_MUL_FILE)
            op_d = mmno_pkg::OP_MULTIPLY_BY_FILE;
        else if (instr_q[15:9] == mmno_pkg::OPC_STORE_ACC)
            op_d = mmno_pkg::OP_STORE_ACCUMULATOR_TO_FILE;
        else if (instr_q[15:9] == mmno_pkg::OPC_NEG_FILE)
            op_d = mmno_pkg::OP_NEGATE_FILE;
    end

    // Effective file address
    always_comb
    begin
        // RL4 - banked when access bit set
        if (instr_q[8])
            ea_d = {bank_q, instr_q[7:0]};
        // RL5 - indexed literal offset
        else if (ext_q && instr_q[7:0] <= mmno_pkg::IDX_LIMIT)
            ea_d = index_q + {4'h0, instr_q[7:0]};
        // RL3 - access bank split on field
        else if (instr_q[7:0] < mmno_pkg::ACC_SPLIT)
            ea_d = {mmno_pkg::ACC_LOW_BANK, instr_q[7:0]};
        else
            ea_d = {mmno_pkg::ACC_HIGH_BANK, instr_q[7:0]};
    end

    // Decode, read and process phases
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            op_q <= mmno_pkg::OP_NO_OP;
            ea_q <= mmno_pkg::RST_ADDR;
            opnd_q <= mmno_pkg::RST_BYTE;
            prod_res_q <= 16'h0000;
            neg_res_q <= mmno_pkg::RST_BYTE;
            neg_flags_q <= 5'h00;
        end
        else
        begin
            if (ph_decode)
            begin
                op_q <= op_d;
                ea_q <= ea_d;
            end
            // RL10 - literal read in second phase
            if (ph_read)
            begin
                case (op_q)
                    mmno_pkg::OP_MULTIPLY_BY_FILE,
                    mmno_pkg::OP_NEGATE_FILE: opnd_q <= mem_q[ea_q];
                    default: opnd_q <= instr_q[7:0];
                endcase
            end
            if (ph_process)
            begin
                // RL6 - unsigned 8x8 product
                prod_res_q <= {8'h00, acc_q} * {8'h00, opnd_q};
                // RL9 - inverted plus one and flags
                neg_res_q <= ~opnd_q + 8'h01;
                neg_flags_q[mmno_pkg::ST_C] <= (opnd_q == mmno_pkg::RST_BYTE);
                neg_flags_q[mmno_pkg::ST_DC] <= (opnd_q[3:0] == 4'h0);
                neg_flags_q[mmno_pkg::ST_Z] <= (opnd_q == mmno_pkg::RST_BYTE);
                neg_flags_q[mmno_pkg::ST_OV] <= (opnd_q == mmno_pkg::NEG_OV_VAL);
                neg_flags_q[mmno_pkg::ST_N] <= opnd_q[7] ^ (opnd_q[6:0] != 7'h00);
            end
        end
    end

    // Accumulator
    always_ff @(posedge clk)
    begin
        if (rst)
            acc_q <= mmno_pkg::RST_BYTE;
        // RL1 - immediate into accumulator
        else if (ph_write && op_q == mmno_pkg::OP_LOAD_ACCUMULATOR_LITERAL)
            acc_q <= instr_q[7:0];
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_ACC)
            acc_q <= wr_val[7:0];
    end

    // Bank select, four stored bits
    always_ff @(posedge clk)
    begin
        if (rst)
            bank_q <= 4'h0;
        // RL10 - bank written in fourth phase
        // RL11 - upper nibble dropped
        else if (ph_write && op_q == mmno_pkg::OP_LOAD_BANK_LITERAL)
            bank_q <= instr_q[3:0];
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_BANK)
            bank_q <= wr_val[3:0];
    end

    // Product pair
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            product_low_byte_q <= mmno_pkg::RST_BYTE;
            product_high_byte_q <= mmno_pkg::RST_BYTE;
        end
        // RL6 - high byte to high register
        // RL7 - file product, sources untouched
        else if (ph_write && (op_q == mmno_pkg::OP_MULTIPLY_BY_LITERAL
                 || op_q == mmno_pkg::OP_MULTIPLY_BY_FILE))
        begin
            product_high_byte_q <= prod_res_q[15:8];
            product_low_byte_q <= prod_res_q[7:0];
        end
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_PRODUCT_LOW_BYTE)
            product_low_byte_q <= wr_val[7:0];
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_PRODUCT_HIGH_BYTE)
            product_high_byte_q <= wr_val[7:0];
    end

    // Status flags; only negate and software writes change them
    always_ff @(posedge clk)
    begin
        if (rst)
            status_q <= 5'h00;
        // RL8 - multiplies leave flags
        // RL9 - negate updates five flags
        else if (ph_write && op_q == mmno_pkg::OP_NEGATE_FILE)
            status_q <= neg_flags_q;
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_STATUS)
            status_q <= wr_val[4:0];
    end

    // Control, index base and memory pointer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ext_q <= 1'b0;
            index_q <= mmno_pkg::RST_ADDR;
            maddr_q <= mmno_pkg::RST_ADDR;
        end
        else if (sw_wr)
        begin
            if (awaddr_q == mmno_pkg::OFS_CTRL)
                ext_q <= wr_val[mmno_pkg::CTRL_EXT];
            if (awaddr_q == mmno_pkg::OFS_INDEX)
                index_q <= wr_val[11:0];
            if (awaddr_q == mmno_pkg::OFS_MADDR)
                maddr_q <= wr_val[11:0];
        end
    end

    // File storage; contents are not cleared by reset
    always_ff @(posedge clk)
    begin
        // RL2 - accumulator to file
        if (ph_write && op_q == mmno_pkg::OP_STORE_ACCUMULATOR_TO_FILE)
            mem_q[ea_q] <= acc_q;
        // RL9 - result back to file
        else if (ph_write && op_q == mmno_pkg::OP_NEGATE_FILE)
            mem_q[ea_q] <= neg_res_q;
        // RL12 - no-op writes nothing
        else if (sw_wr && awaddr_q == mmno_pkg::OFS_MDATA)
            mem_q[maddr_q] <= wr_val[7:0];
    end
endmodule

// ===== common/mmno_pkg.sv
// Constants and types for the move/multiply/negate execution block
package mmno_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FILE_AW = 12;
    localparam int MEM_DEPTH = 4096;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_BANK = 8'h0c;
    localparam logic [7:0] OFS_PRODUCT_LOW_BYTE = 8'h10;
    localparam logic [7:0] OFS_PRODUCT_HIGH_BYTE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_INDEX = 8'h1c;
    localparam logic [7:0] OFS_MADDR = 8'h20;
    localparam logic [7:0] OFS_MDATA = 8'h24;
    // Status field positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam int ST_BUSY = 8;
    localparam int CTRL_EXT = 0;
    // Opcode fields
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
    localparam logic [7:0] OPC_LOAD_ACC = 8'h0e;
    localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC_STORE_ACC = 7'h37;
    localparam logic [6:0] OPC_NEG_FILE = 7'h36;
    // Addressing constants
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0] NEG_OV_VAL = 8'h80;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_ADDR = 12'h000;
    localparam logic [15:0] RST_INSTR = 16'h0000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Quarter phases
    localparam logic [1:0] QP_DECODE = 2'h0;
    localparam logic [1:0] QP_READ = 2'h1;
    localparam logic [1:0] QP_PROCESS = 2'h2;
    localparam logic [1:0] QP_WRITE = 2'h3;
    localparam logic [1:0] QP_STEP = 2'h1;
    typedef enum logic [2:0] {
        OP_NO_OP,
        OP_LOAD_BANK_LITERAL,
        OP_LOAD_ACCUMULATOR_LITERAL,
        OP_STORE_ACCUMULATOR_TO_FILE,
        OP_MULTIPLY_BY_LITERAL,
        OP_MULTIPLY_BY_FILE,
        OP_NEGATE_FILE
    } mmno_op_t;
endpackage

// ===== verif/mmno_core_assertions.sv
// Bus-side checker for the move/multiply/negate core
`timescale 1ns/1ps
module mmno_core_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [7:0] ar_q;
    logic mapped;
    // Address of the read in flight
    always_ff @(posedge clk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            ar_q <= s_axi_araddr;
        end
    end
    assign mapped = (ar_q[1:0] == 2'h0) && (ar_q <= mmno_pkg::OFS_MDATA);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_bank_upper_zero: assert property (s_axi_rvalid && ar_q == mmno_pkg::OFS_BANK
        |-> s_axi_rdata[31:4] == 28'h0)
        else $error("bank upper bits set");
    a_acc_byte_only: assert property (s_axi_rvalid && ar_q == mmno_pkg::OFS_ACC
        |-> s_axi_rdata[31:8] == 24'h0)
        else $error("accumulator wider than a byte");
    a_prod_byte_only: assert property (s_axi_rvalid
        && (ar_q == mmno_pkg::OFS_PRODUCT_LOW_BYTE
        || ar_q == mmno_pkg::OFS_PRODUCT_HIGH_BYTE)
        |-> s_axi_rdata[31:8] == 24'h0)
        else $error("product byte too wide");
    a_status_fields: assert property (s_axi_rvalid && ar_q == mmno_pkg::OFS_STATUS
        |-> s_axi_rdata[31:9] == 23'h0 && s_axi_rdata[7:5] == 3'h0)
        else $error("status reserved bits set");
    a_unmapped_err: assert property (s_axi_rvalid && !mapped
        |-> s_axi_rresp == mmno_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (s_axi_rvalid && mapped
        |-> s_axi_rresp == mmno_pkg::RESP_OKAY)
        else $error("mapped read refused");
endmodule
bind mmno_core mmno_core_assertions u_chk (.clk, .rst, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready);

// ===== verif/mmno_core_tb_top.sv
// Register-level testbench for the move/multiply/negate core
`timescale 1ns/1ps
module mmno_core_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awa = 8'h00;
    logic awv = 1'b0;
    logic awr;
    logic [31:0] wd = 32'h0;
    logic wv = 1'b0;
    logic wr_rdy;
    logic [1:0] br;
    logic bv;
    logic bre = 1'b0;
    logic [7:0] ara = 8'h00;
    logic arv = 1'b0;
    logic arr;
    logic [31:0] rd;
    logic [1:0] rr;
    logic rv;
    logic rre = 1'b0;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] v;
    logic [1:0] rs;
    logic [7:0] nr;
    logic [31:0] fl;
    logic [7:0] nx [4] = '{8'h3a, 8'h00, 8'h01, 8'h80};
    mmno_core uut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
    always #5 clk = ~clk;
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        n = 0;
        @(posedge clk);
        awa <= a;
        awv <= 1'b1;
        wd <= d;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(aw_ok && w_ok) && n < 50)
        begin
            @(posedge clk);
            n++;
            if (!aw_ok && awr === 1'b1)
            begin
                awv <= 1'b0;
                aw_ok = 1;
            end
            if (!w_ok && wr_rdy === 1'b1)
            begin
                wv <= 1'b0;
                w_ok = 1;
            end
        end
        while (bv !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        r = br;
        bre <= 1'b0;
        if (n >= 50)
        begin
            err_total++;
        end
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (arr !== 1'b1 && n < 50);
        arv <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rv !== 1'b1 && n < 50);
        d = rd;
        r = rr;
        rre <= 1'b0;
        if (n >= 50)
        begin
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check_val(nm, e, d);
    endtask
    // Start one instruction, then poll busy with a bound
    task automatic exec(input logic [15:0] i);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(mmno_pkg::OFS_INSTR, {16'h0000, i});
        n = 0;
        do
        begin
            axi_read(mmno_pkg::OFS_STATUS, d, r);
            n++;
        end
        while (d[mmno_pkg::ST_BUSY] !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            err_total++;
        end
    endtask
    task automatic file_set(input logic [11:0] a, input logic [7:0] d);
        wr(mmno_pkg::OFS_MADDR, {20'h0, a});
        wr(mmno_pkg::OFS_MDATA, {24'h0, d});
    endtask
    task automatic file_chk(input logic [11:0] a, input logic [7:0] e);
        wr(mmno_pkg::OFS_MADDR, {20'h0, a});
        rd_chk("file", mmno_pkg::OFS_MDATA, {24'h0, e});
    endtask
    initial
    begin
        #300000;
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk("bank", mmno_pkg::OFS_BANK, 32'h0);
        axi_read(8'h28, v, rs);
        check_resp("rresp", mmno_pkg::RESP_SLVERR, rs);
        axi_write(8'h2c, 32'h1, rs);
        check_resp("bresp", mmno_pkg::RESP_SLVERR, rs);
        exec(16'h0e5a);
        rd_chk("acc", mmno_pkg::OFS_ACC, 32'h5a);
        rd_chk("status", mmno_pkg::OFS_STATUS, 32'h0);
        exec(16'h01f5);
        rd_chk("bank", mmno_pkg::OFS_BANK, 32'h5);
        exec(16'h6f33);
        file_chk(12'h533, 8'h5a);
        exec(16'h6e10);
        file_chk(12'h010, 8'h5a);
        exec(16'h6e90);
        file_chk(12'hf90, 8'h5a);
        // Indexed mode, at the limit and one past it
        wr(mmno_pkg::OFS_CTRL, 32'h1);
        wr(mmno_pkg::OFS_INDEX, 32'h200);
        file_set(12'h060, 8'h00);
        exec(16'h6e5f);
        file_chk(12'h25f, 8'h5a);
        exec(16'h6e60);
        file_chk(12'h060, 8'h5a);
        wr(mmno_pkg::OFS_CTRL, 32'h0);
        exec(16'h0ee2);
        exec(16'h0dc4);
        rd_chk("product_high_byte", mmno_pkg::OFS_PRODUCT_HIGH_BYTE, 32'had);
        rd_chk("product_low_byte", mmno_pkg::OFS_PRODUCT_LOW_BYTE, 32'h08);
        rd_chk("acc", mmno_pkg::OFS_ACC, 32'he2);
        for (int i = 0; i < 4; i++)
        begin
            nr = ~nx[i] + 8'h01;
            fl = 32'h0;
            fl[mmno_pkg::ST_C] = (nx[i] == 8'h00);
            fl[mmno_pkg::ST_DC] = (nx[i][3:0] == 4'h0);
            fl[mmno_pkg::ST_Z] = (nr == 8'h00);
            fl[mmno_pkg::ST_OV] = (nx[i] == 8'h80);
            fl[mmno_pkg::ST_N] = nr[7];
            file_set(12'h5a0, nx[i]);
            exec(16'h6da0);
            file_chk(12'h5a0, nr);
            rd_chk("status", mmno_pkg::OFS_STATUS, fl);
        end
        // Flags now nonzero, so kept flags are visible
        file_set(12'h5ab, 8'hb5);
        exec(16'h0ec4);
        exec(16'h03ab);
        rd_chk("product_high_byte", mmno_pkg::OFS_PRODUCT_HIGH_BYTE, 32'h8a);
        rd_chk("product_low_byte", mmno_pkg::OFS_PRODUCT_LOW_BYTE, 32'h94);
        file_chk(12'h5ab, 8'hb5);
        rd_chk("acc", mmno_pkg::OFS_ACC, 32'hc4);
        rd_chk("status", mmno_pkg::OFS_STATUS, fl);
        exec(16'h0d00);
        rd_chk("product_low_byte", mmno_pkg::OFS_PRODUCT_LOW_BYTE, 32'h0);
        rd_chk("status", mmno_pkg::OFS_STATUS, fl);
        exec(16'h6f40);
        file_chk(12'h540, 8'hc4);
        rd_chk("status", mmno_pkg::OFS_STATUS, fl);
        exec(16'h0000);
        exec(16'hf123);
        rd_chk("acc", mmno_pkg::OFS_ACC, 32'hc4);
        rd_chk("bank", mmno_pkg::OFS_BANK, 32'h5);
        rd_chk("status", mmno_pkg::OFS_STATUS, fl);
        stop_test();
    end
endmodule
